// >>> rtl/p0mux_pkg.sv
// Purpose: Constants and types for the port pin function multiplexer.
// Assumes: Three pins of the first port bank, one mode word each.
// Notes:   Function codes and field positions are shared by all files.
package p0mux_pkg;

    // ********************************************************************
    // Register map and fields
    // ********************************************************************
    localparam int          NPINS        = 3;
    localparam int          FIRST_PIN    = 1;
    localparam logic [31:0] REG_IDX_PIN1 = 32'h5000_3008;
    localparam logic [31:0] REG_IDX_PIN2 = 32'h5000_300A;
    localparam logic [31:0] REG_IDX_PIN3 = 32'h5000_300C;
    localparam int          PDIR_LSB     = 8;
    localparam int          PDIR_MSB     = 9;
    localparam int          FSEL_LSB     = 0;
    localparam int          FSEL_MSB     = 4;
    localparam logic [15:0] MODE_WMASK   = 16'h031F;
    localparam logic [15:0] MODE_RESET   = 16'h0200;
    localparam int          ANALOG_LIMIT = 4;
    localparam int          DIAG_LIMIT   = 8;

    // ********************************************************************
    // Direction field codes
    // ********************************************************************
    localparam logic [1:0] PD_IN_NONE = 2'h0;
    localparam logic [1:0] PD_IN_UP   = 2'h1;
    localparam logic [1:0] PD_IN_DOWN = 2'h2;
    localparam logic [1:0] PD_OUT     = 2'h3;

    // ********************************************************************
    // Function select codes
    // ********************************************************************
    localparam logic [4:0] FS_PORT    = 5'h00;
    localparam logic [4:0] FS_UA_RX   = 5'h01;
    localparam logic [4:0] FS_UA_TX   = 5'h02;
    localparam logic [4:0] FS_UB_RX   = 5'h03;
    localparam logic [4:0] FS_UB_TX   = 5'h04;
    localparam logic [4:0] FS_SER_DI  = 5'h05;
    localparam logic [4:0] FS_SPI_DO  = 5'h06;
    localparam logic [4:0] FS_SPI_CLK = 5'h07;
    localparam logic [4:0] FS_SPI_EN  = 5'h08;
    localparam logic [4:0] FS_SCL     = 5'h09;
    localparam logic [4:0] FS_SDA     = 5'h0A;
    localparam logic [4:0] FS_IRA_RX  = 5'h0B;
    localparam logic [4:0] FS_IRA_TX  = 5'h0C;
    localparam logic [4:0] FS_IRB_TX  = 5'h0D;
    localparam logic [4:0] FS_UNUSED  = 5'h0E;
    localparam logic [4:0] FS_ANALOG  = 5'h0F;
    localparam logic [4:0] FS_PULSE0  = 5'h10;
    localparam logic [4:0] FS_PULSE1  = 5'h11;
    localparam logic [4:0] FS_DIAG    = 5'h12;
    localparam logic [4:0] FS_CTS_A   = 5'h13;
    localparam logic [4:0] FS_RTS_A   = 5'h14;
    localparam logic [4:0] FS_CTS_B   = 5'h15;
    localparam logic [4:0] FS_RTS_B   = 5'h16;
    localparam logic [4:0] FS_PULSE2  = 5'h17;
    localparam logic [4:0] FS_PULSE3  = 5'h18;
    localparam logic [4:0] FS_PULSE4  = 5'h19;

    // ********************************************************************
    // Peripheral input functions
    // ********************************************************************
    localparam int         NFIN       = 8;
    localparam int         FIN_UA_RX  = 0;
    localparam int         FIN_UB_RX  = 1;
    localparam int         FIN_SER_DI = 2;
    localparam int         FIN_SCL    = 3;
    localparam int         FIN_SDA    = 4;
    localparam int         FIN_IRA_RX = 5;
    localparam int         FIN_CTS_A  = 6;
    localparam int         FIN_CTS_B  = 7;
    localparam logic [7:0] FIN_IDLE   = 8'hFF;

    typedef logic [NFIN-1:0] p0mux_fin_t;

    function automatic logic [4:0] p0mux_fin_code(input int k);
        logic [4:0] c;
        c = FS_PORT;
        case (k)
            FIN_UA_RX:  c = FS_UA_RX;
            FIN_UB_RX:  c = FS_UB_RX;
            FIN_SER_DI: c = FS_SER_DI;
            FIN_SCL:    c = FS_SCL;
            FIN_SDA:    c = FS_SDA;
            FIN_IRA_RX: c = FS_IRA_RX;
            FIN_CTS_A:  c = FS_CTS_A;
            FIN_CTS_B:  c = FS_CTS_B;
            default:    c = FS_PORT;
        endcase
        return c;
    endfunction

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic       uart_a_transmit;
        logic       uart_b_transmit;
        logic       serial_periph_data_out;
        logic       serial_periph_clock;
        logic       serial_periph_enable;
        logic       twowire_clock_low;
        logic       twowire_data_low;
        logic       uart_a_infrared_transmit;
        logic       uart_b_infrared_transmit;
        logic       uart_a_request_to_send_n;
        logic       uart_b_request_to_send_n;
        logic [4:0] pulse_out;
        logic [7:0] radio_diagnostic_bus;
    } p0mux_pout_s;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_dn;
        logic analog;
    } p0mux_pad_s;

endpackage

// >>> rtl/p0mux_pin.sv
// Purpose: Function decode for one pin of the first port bank.
// Assumes: Mode word and peripheral outputs come from the same clock domain.
// Notes:   Purely combinational; the top registers every result.
`timescale 1ns/1ps
module p0mux_pin
    import p0mux_pkg::*;
#(
    parameter int PIN_IDX = 1
) (
    // Configuration
    input  wire logic [15:0]  mode,
    // Sources
    input  wire logic         gpio_out,
    input  wire p0mux_pout_s  pout,
    // Results
    output p0mux_pad_s        pad,
    output p0mux_fin_t        fin_claim
);

    // ********************************************************************
    // Decode
    // ********************************************************************
    logic [1:0]  pdir;
    logic [4:0]  fsel;
    logic [4:0]  code;
    logic [31:0] out_tab;
    logic [31:0] out_mask;
    logic        known;
    logic        is_out;
    logic        is_in;
    logic        is_i2c;
    logic        i2c_low;

    assign pdir = mode[PDIR_MSB:PDIR_LSB];
    assign fsel = mode[FSEL_MSB:FSEL_LSB];

    // Codes with no function, or with a function this pin lacks, fall back.
    assign known = (fsel <= FS_PULSE4) && (fsel != FS_UNUSED) &&
                   !(fsel == FS_ANALOG && PIN_IDX >= ANALOG_LIMIT) &&
                   !(fsel == FS_DIAG && PIN_IDX >= DIAG_LIMIT);
    assign code  = known ? fsel : FS_PORT;

    always_comb begin
        out_tab                = 32'h0000_0000;
        out_mask               = 32'h0000_0000;
        out_tab[FS_UA_TX]      = pout.uart_a_transmit;
        out_tab[FS_UB_TX]      = pout.uart_b_transmit;
        out_tab[FS_SPI_DO]     = pout.serial_periph_data_out;
        out_tab[FS_SPI_CLK]    = pout.serial_periph_clock;
        out_tab[FS_SPI_EN]     = pout.serial_periph_enable;
        out_tab[FS_IRA_TX]     = pout.uart_a_infrared_transmit;
        out_tab[FS_IRB_TX]     = pout.uart_b_infrared_transmit;
        out_tab[FS_PULSE0]     = pout.pulse_out[0];
        out_tab[FS_PULSE1]     = pout.pulse_out[1];
        out_tab[FS_PULSE2]     = pout.pulse_out[2];
        out_tab[FS_PULSE3]     = pout.pulse_out[3];
        out_tab[FS_PULSE4]     = pout.pulse_out[4];
        out_tab[FS_DIAG]       = pout.radio_diagnostic_bus[PIN_IDX];
        out_tab[FS_RTS_A]      = pout.uart_a_request_to_send_n;
        out_tab[FS_RTS_B]      = pout.uart_b_request_to_send_n;
        out_mask[FS_UA_TX]     = 1'b1;
        out_mask[FS_UB_TX]     = 1'b1;
        out_mask[FS_SPI_DO]    = 1'b1;
        out_mask[FS_SPI_CLK]   = 1'b1;
        out_mask[FS_SPI_EN]    = 1'b1;
        out_mask[FS_IRA_TX]    = 1'b1;
        out_mask[FS_IRB_TX]    = 1'b1;
        out_mask[FS_PULSE0]    = 1'b1;
        out_mask[FS_PULSE1]    = 1'b1;
        out_mask[FS_PULSE2]    = 1'b1;
        out_mask[FS_PULSE3]    = 1'b1;
        out_mask[FS_PULSE4]    = 1'b1;
        out_mask[FS_DIAG]      = 1'b1;
        out_mask[FS_RTS_A]     = 1'b1;
        out_mask[FS_RTS_B]     = 1'b1;
    end

    assign is_out  = out_mask[code];
    assign is_i2c  = (code == FS_SCL) || (code == FS_SDA);
    assign i2c_low = (code == FS_SCL) ? pout.twowire_clock_low
                                      : pout.twowire_data_low;
    assign is_in   = !is_out && !is_i2c && (code != FS_ANALOG) &&
                     !(code == FS_PORT && pdir == PD_OUT);

    // ********************************************************************
    // Pad control
    // ********************************************************************
    // The two-wire lines are open drain: only ever driven low.
    assign pad.out     = is_out ? out_tab[code] :
                         (code == FS_PORT) ? gpio_out : 1'b0;
    assign pad.oe      = is_out ||
                         (is_i2c && i2c_low) ||
                         (code == FS_PORT && pdir == PD_OUT);
    assign pad.pull_up = is_in && (pdir == PD_IN_UP);
    assign pad.pull_dn = is_in && (pdir == PD_IN_DOWN);
    assign pad.analog  = (code == FS_ANALOG);

    for (genvar k = 0; k < NFIN; k++) begin : g_claim
        assign fin_claim[k] = (code == p0mux_fin_code(k));
    end

endmodule

// >>> rtl/p0mux_top.sv
// Purpose: AHB-Lite mode registers and pin multiplexing for pins 1 to 3.
// Assumes: Pin 0 of the bank reports its input claims on pin0_claim.
// Notes:   Zero wait state slave; every output is a flip-flop.
`timescale 1ns/1ps
module p0mux_top
    import p0mux_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                srst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    // Pads
    input  wire logic [NPINS-1:0]    pad_in,
    output p0mux_pad_s [NPINS-1:0]   pad_ctl,
    // Port data logic
    input  wire logic [NPINS-1:0]    gpio_out,
    output logic [NPINS-1:0]         gpio_in,
    // Peripherals
    input  wire p0mux_pout_s         pout,
    input  wire p0mux_fin_t          pin0_claim,
    input  wire p0mux_fin_t          pin0_value,
    output p0mux_fin_t               fin_value,
    output p0mux_fin_t               fin_claimed
);

    // ********************************************************************
    // Bus slave
    // ********************************************************************
    logic [15:0]      mode_reg [NPINS];
    logic [15:0]      mode_next [NPINS];
    logic             wr_pend_reg;
    logic [NPINS-1:0] wr_sel_reg;
    logic [NPINS-1:0] addr_hit;
    logic             take;
    logic [31:0]      rd_next;

    // Byte address is four times the index, modulo the 32-bit space.
    assign addr_hit[0] = (haddr[31:2] == REG_IDX_PIN1[29:0]);
    assign addr_hit[1] = (haddr[31:2] == REG_IDX_PIN2[29:0]);
    assign addr_hit[2] = (haddr[31:2] == REG_IDX_PIN3[29:0]);
    assign take        = hsel && htrans[1] && hready;

    for (genvar i = 0; i < NPINS; i++) begin : g_mode
        assign mode_next[i] = (wr_pend_reg && wr_sel_reg[i]) ?
                              (hwdata[15:0] & MODE_WMASK) : mode_reg[i];
    end

    // Reads use the next value so a read right after a write sees it.
    assign rd_next = addr_hit[0] ? {16'h0000, mode_next[0]} :
                     addr_hit[1] ? {16'h0000, mode_next[1]} :
                     addr_hit[2] ? {16'h0000, mode_next[2]} :
                     32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg  <= '0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= take && hwrite;
            wr_sel_reg  <= take ? addr_hit : '0;
            hrdata      <= (take && !hwrite) ? rd_next : 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end
    end

    for (genvar i = 0; i < NPINS; i++) begin : g_mreg
        always_ff @(posedge core_clk) begin
            if (srst) begin
                mode_reg[i] <= MODE_RESET;
            end else begin
                mode_reg[i] <= mode_next[i];
            end
        end
    end

    // ********************************************************************
    // Pad input synchroniser
    // ********************************************************************
    logic [NPINS-1:0] pad_meta_reg;
    logic [NPINS-1:0] pad_sync_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pad_meta_reg <= '0;
            pad_sync_reg <= '0;
        end else begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    // ********************************************************************
    // Per-pin decode and input priority
    // ********************************************************************
    p0mux_pad_s       pad_c [NPINS];
    p0mux_fin_t       claim_c [NPINS];
    p0mux_fin_t       fin_v_c;
    p0mux_fin_t       fin_k_c;

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        p0mux_pin #(
            .PIN_IDX (FIRST_PIN + i)
        ) u_pin (
            .mode      (mode_reg[i]),
            .gpio_out  (gpio_out[i]),
            .pout      (pout),
            .pad       (pad_c[i]),
            .fin_claim (claim_c[i])
        );
    end

    // Walk from the highest pin down so the lowest claimer is left standing.
    // The claimed mask lets the second bank yield to this one.
    always_comb begin
        fin_v_c = FIN_IDLE;
        fin_k_c = pin0_claim;
        for (int i = NPINS - 1; i >= 0; i--) begin
            for (int k = 0; k < NFIN; k++) begin
                if (claim_c[i][k]) begin
                    fin_v_c[k] = pad_sync_reg[i];
                    fin_k_c[k] = 1'b1;
                end
            end
        end
        for (int k = 0; k < NFIN; k++) begin
            if (pin0_claim[k]) begin
                fin_v_c[k] = pin0_value[k];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fin_value   <= FIN_IDLE;
            fin_claimed <= '0;
            gpio_in     <= '0;
        end else begin
            fin_value   <= fin_v_c;
            fin_claimed <= fin_k_c;
            gpio_in     <= pad_sync_reg;
        end
    end

    for (genvar i = 0; i < NPINS; i++) begin : g_pad
        always_ff @(posedge core_clk) begin
            if (srst) begin
                pad_ctl[i] <= '{out: 1'b0, oe: 1'b0, pull_up: 1'b0,
                                pull_dn: 1'b1, analog: 1'b0};
            end else begin
                pad_ctl[i] <= pad_c[i];
            end
        end
    end

    // ********************************************************************
    // Checks on pin 1
    // ********************************************************************
    logic [1:0] pd0;
    logic [4:0] fs0;
    assign pd0 = mode_reg[0][PDIR_MSB:PDIR_LSB];
    assign fs0 = mode_reg[0][FSEL_MSB:FSEL_LSB];

    a_dir_input: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_PORT && pd0 != PD_OUT) |=> (!pad_ctl[0].oe &&
        pad_ctl[0].pull_up == $past(pd0 == PD_IN_UP) &&
        pad_ctl[0].pull_dn == $past(pd0 == PD_IN_DOWN)))
        else $error("Port input pull mismatch.");
    a_dir_output: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_PORT && pd0 == PD_OUT) |=> (pad_ctl[0].oe &&
        pad_ctl[0].out == $past(gpio_out[0]) && !pad_ctl[0].pull_dn))
        else $error("Port output not driven.");
    a_analog_free: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_ANALOG) |=> (pad_ctl[0].analog && !pad_ctl[0].oe &&
        !pad_ctl[0].pull_up && !pad_ctl[0].pull_dn))
        else $error("Analog pin not released.");
    a_uart_tx: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_UB_TX) |=> (pad_ctl[0].oe &&
        pad_ctl[0].out == $past(pout.uart_b_transmit)))
        else $error("UART B transmit not routed.");
    a_spi_clk: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_SPI_CLK) |=> (pad_ctl[0].oe &&
        pad_ctl[0].out == $past(pout.serial_periph_clock)))
        else $error("Serial clock not routed.");
    a_i2c_drain: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_SDA) |=> (!pad_ctl[0].out &&
        pad_ctl[0].oe == $past(pout.twowire_data_low)))
        else $error("Two-wire data not open drain.");
    a_irda_tx: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_IRB_TX) |=>
        (pad_ctl[0].out == $past(pout.uart_b_infrared_transmit)))
        else $error("Infrared transmit not routed.");
    a_pwm_route: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_PULSE3) |=> (pad_ctl[0].oe &&
        pad_ctl[0].out == $past(pout.pulse_out[3])))
        else $error("Pulse output 3 not routed.");
    a_diag_bit: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_DIAG) |=>
        (pad_ctl[0].out == $past(pout.radio_diagnostic_bus[FIRST_PIN])))
        else $error("Diagnostic bit not routed.");
    a_rts_route: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_RTS_A) |=>
        (pad_ctl[0].out == $past(pout.uart_a_request_to_send_n)))
        else $error("UART A request to send not routed.");
    a_prio_low: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 == FS_UA_RX && !pin0_claim[FIN_UA_RX]) |=>
        (fin_value[FIN_UA_RX] == $past(pad_sync_reg[0]) &&
        fin_claimed[FIN_UA_RX]))
        else $error("Lowest pin lost input priority.");
    a_reset_mode: assert property (@(posedge core_clk)
        srst |=> (mode_reg[0] == MODE_RESET && pad_ctl[0].pull_dn &&
        !pad_ctl[0].oe))
        else $error("Reset state wrong.");
    a_unassigned: assert property (@(posedge core_clk) disable iff (srst)
        (fs0 > FS_PULSE4 && pd0 == PD_OUT) |=>
        (pad_ctl[0].out == $past(gpio_out[0]) && pad_ctl[0].oe))
        else $error("Unassigned code not port function.");

endmodule

// >>> dv/p0mux_far_model.sv
// Purpose: Far side of the pins: pad sources and peripheral endpoints.
// Assumes: A driven pad follows its output; otherwise its pull, else an outside source.
// Notes:   New random stimulus on each edge while shuffle is high.
`timescale 1ns/1ps
module p0mux_far_model
    import p0mux_pkg::*;
(
    // Clock and control
    input  wire logic                   core_clk,
    input  wire logic                   shuffle,
    // Pads
    input  wire p0mux_pad_s [NPINS-1:0] pad_ctl,
    output logic [NPINS-1:0]            pad_in,
    output logic [NPINS-1:0]            ext = '0,
    // Peripherals
    output p0mux_pout_s                 pout = '0,
    output p0mux_fin_t                  pin0_claim = '0,
    output p0mux_fin_t                  pin0_value = '0
);
    // Pin 0 claims are sparse, so that pins 1 to 3 still win most inputs.
    always @(posedge core_clk) begin
        if (shuffle) begin
            ext        <= NPINS'($urandom);
            pout       <= p0mux_pout_s'($urandom);
            pin0_claim <= p0mux_fin_t'($urandom & $urandom & $urandom);
            pin0_value <= p0mux_fin_t'($urandom);
        end
    end
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            // An undriven pad with a pull settles at the pull's level.
            pad_in[i] = (pad_ctl[i].oe === 1'b1) ? pad_ctl[i].out :
                        (pad_ctl[i].pull_up === 1'b1) ? 1'b1 :
                        (pad_ctl[i].pull_dn === 1'b1) ? 1'b0 : ext[i];
        end
    end
endmodule

// >>> dv/p0mux_top_bench.sv
// Purpose: Self-checking bench for the port pin function multiplexer.
// Assumes: Zero wait state bus; outputs settle within five edges.
// Notes:   A reference model predicts every pad, claim and input value.
`timescale 1ns/1ps
module p0mux_top_bench;
    import p0mux_pkg::*;
    logic                   core_clk = 1'b0, srst = 1'b1, shuffle = 1'b1;
    logic                   hsel = 1'b0, hwrite = 1'b0, rdy_q, rsp_q;
    logic [1:0]             htrans = 2'h0;
    logic [31:0]            haddr = '0, hwdata = '0, hrdata, rd_q, d;
    logic                   hreadyout, hresp;
    logic [NPINS-1:0]       pad_in, ext, gpio_in, gpio_out = '0;
    logic [4:0]             sh;
    p0mux_pad_s [NPINS-1:0] pad_ctl;
    p0mux_pout_s            pout;
    p0mux_fin_t             pin0_claim, pin0_value, fin_value, fin_claimed;
    logic [15:0]            mreg [NPINS];
    int                     fail_count = 0, checks = 0;
    localparam logic [4:0]  FCODE [NFIN] = '{5'h01, 5'h03, 5'h05, 5'h09,
                                             5'h0A, 5'h0B, 5'h13, 5'h15};
    localparam logic [31:0] IDX [NPINS] = '{REG_IDX_PIN1, REG_IDX_PIN2,
                                            REG_IDX_PIN3};
    p0mux_top p0mux_top_i (.core_clk(core_clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pad_in(pad_in), .pad_ctl(pad_ctl),
        .gpio_out(gpio_out), .gpio_in(gpio_in), .pout(pout),
        .pin0_claim(pin0_claim), .pin0_value(pin0_value),
        .fin_value(fin_value), .fin_claimed(fin_claimed));
    p0mux_far_model p0mux_far_model_i (.core_clk(core_clk),
        .shuffle(shuffle), .pad_ctl(pad_ctl), .pad_in(pad_in), .ext(ext),
        .pout(pout), .pin0_claim(pin0_claim), .pin0_value(pin0_value));
    always #2 core_clk = ~core_clk;
    // Bus answers are captured at the edge, so no race with the design.
    always @(posedge core_clk) begin
        rd_q  <= hrdata;
        rdy_q <= hreadyout;
        rsp_q <= hresp;
    end
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string w, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic rw(input logic wr, input logic [31:0] a, dat);
        logic [31:0] e;
        e = '0;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do step(); while (rdy_q !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= dat;
        do step(); while (rdy_q !== 1'b1);
        for (int p = 0; p < NPINS; p++) begin
            if (a === IDX[p] << 2) begin
                if (wr) mreg[p] = dat[15:0] & MODE_WMASK;
                e = {16'h0, mreg[p]};
            end
        end
        chk("hresp", '0, 32'(rsp_q));
        if (!wr) chk("hrdata", e, rd_q);
    endtask
    function automatic p0mux_pad_s epad(int p);
        logic [1:0] m;
        logic [4:0] c;
        p0mux_pad_s r;
        m = mreg[p][9:8];
        c = mreg[p][4:0];
        r = {gpio_out[p], m == 2'h3, m == 2'h1, m == 2'h2, 1'b0};
        case (c)
            5'h01, 5'h03, 5'h05, 5'h0B, 5'h13, 5'h15: r.oe = 1'b0;
            5'h02: r = {pout.uart_a_transmit, 4'h8};
            5'h04: r = {pout.uart_b_transmit, 4'h8};
            5'h06: r = {pout.serial_periph_data_out, 4'h8};
            5'h07: r = {pout.serial_periph_clock, 4'h8};
            5'h08: r = {pout.serial_periph_enable, 4'h8};
            5'h09: r = {1'b0, pout.twowire_clock_low, 3'h0};
            5'h0A: r = {1'b0, pout.twowire_data_low, 3'h0};
            5'h0C: r = {pout.uart_a_infrared_transmit, 4'h8};
            5'h0D: r = {pout.uart_b_infrared_transmit, 4'h8};
            5'h0F: r = 5'h01;
            5'h10, 5'h11: r = {pout.pulse_out[c[0]], 4'h8};
            5'h17, 5'h18, 5'h19: r = {pout.pulse_out[c - 5'h15], 4'h8};
            5'h12: r = {pout.radio_diagnostic_bus[p + 1], 4'h8};
            5'h14: r = {pout.uart_a_request_to_send_n, 4'h8};
            5'h16: r = {pout.uart_b_request_to_send_n, 4'h8};
            default: ;
        endcase
        return r;
    endfunction
    task automatic check_all();
        logic [NPINS-1:0] pv;
        p0mux_fin_t       ev, ec;
        p0mux_pad_s       e, mk;
        repeat (5) step();
        for (int p = 0; p < NPINS; p++) begin
            e = epad(p);
            mk = {e.oe, 4'hF};
            pv[p] = e.oe ? e.out : e.pull_up ? 1'b1 :
                    e.pull_dn ? 1'b0 : ext[p];
            chk("pad_ctl", 32'(e & mk), 32'(pad_ctl[p] & mk));
        end
        chk("gpio_in", 32'(pv), 32'(gpio_in));
        for (int k = 0; k < NFIN; k++) begin
            {ec[k], ev[k]} = 2'h1;
            for (int p = NPINS - 1; p >= 0; p--) begin
                if (mreg[p][4:0] == FCODE[k]) {ec[k], ev[k]} = {1'b1, pv[p]};
            end
            if (pin0_claim[k]) {ec[k], ev[k]} = {1'b1, pin0_value[k]};
        end
        chk("fin_value", 32'(ev), 32'(fin_value));
        chk("fin_claimed", 32'(ec), 32'(fin_claimed));
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h3606d310));
        foreach (mreg[p]) mreg[p] = 16'h0200;
        repeat (6) @(posedge core_clk);
        srst    <= 1'b0;
        shuffle <= 1'b0;
        #1;
        check_all();
        foreach (mreg[p]) rw(1'b0, IDX[p] << 2, '0);
        rw(1'b1, 32'h4000C024, '1);
        rw(1'b0, 32'h4000C024, '0);
        $display("test reset done");
        // Early passes sweep every code on every pin; later odd ones share a
        // code across pins so that the priority order is exercised.
        for (int i = 0; i < 160; i++) begin
            sh = 5'($urandom);
            for (int p = 0; p < NPINS; p++) begin
                d = $urandom;
                d[4:0] = i < 64 ? 5'(i + 11 * p) : (i % 2 ? sh : d[4:0]);
                rw(1'b1, IDX[p] << 2, d);
            end
            rw(1'b0, IDX[$urandom_range(2, 0)] << 2, '0);
            gpio_out <= NPINS'($urandom);
            shuffle  <= 1'b1;
            step();
            shuffle  <= 1'b0;
            check_all();
        end
        $display("test modes done");
        report_and_stop();
    end
endmodule
